//--- inc/grant_id_pkg.sv
// shared constants and carrier types for the grant identifier decoder
`default_nettype none
package grant_id_pkg;
  localparam int SID_W = 14;
  localparam int IUC_W = 4;
  localparam int SLOT_W = 10;
  localparam int PID_W = 13;
  localparam int PRIO_W = 3;
  localparam int NIB_W = 4;

  // well-known service flow identifiers
  localparam logic [SID_W-1:0] SID_NO_MODEM = 14'h0000;
  localparam logic [SID_W-1:0] SID_INIT_RANGING = 14'h0000;
  localparam logic [SID_W-1:0] SID_ALL_MODEM = 14'h3fff;
  localparam logic [9:0] SID_MCAST_HI = 10'h3ff;
  localparam logic [NIB_W-1:0] MCAST_N_MIN = 4'h1;
  localparam logic [NIB_W-1:0] MCAST_N_MAX = 4'he;
  localparam logic [5:0] SID_PRIO_HI = 6'h3e;
  localparam int MCAST_HI_LSB = 4;
  localparam int PRIO_HI_LSB = 8;

  // interval usage codes; plain defaults, adjust to the upstream profile in use
  localparam logic [IUC_W-1:0] IUC_REQUEST = 4'h1;
  localparam logic [IUC_W-1:0] IUC_REQ_DATA = 4'h2;
  localparam logic [IUC_W-1:0] IUC_INIT_MAINT = 4'h3;

  // destination addresses, first octet in bits 47:40
  localparam logic [47:0] MAC_ALL_MODEM = 48'h01e02f000001;
  localparam logic [43:0] MAC_RSVD_HI = 44'h01e02f00000;
  localparam logic [3:0] MAC_RSVD_LO_MIN = 4'h2;
  localparam int MAC_RSVD_HI_LSB = 4;
  localparam int MAC_GROUP_BIT = 40;

  localparam logic [PID_W-1:0] PID_DATA = 13'h1ffe;

  // carrier watchdog: longest legal burst, as a time, and in clock cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int TX_LIMIT_US = 2000;
  localparam int TX_LIMIT_CYCLES = (TX_LIMIT_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_UNICAST,
    CLS_NO_MODEM,
    CLS_ALL_MODEM,
    CLS_MULTICAST,
    CLS_PRIORITY,
    CLS_OTHER
  } sid_class_e;

  typedef struct packed {
    logic valid;
    logic [SID_W-1:0] service_flow_id;
    logic [IUC_W-1:0] interval_usage_code;
    logic [SLOT_W-1:0] tx_offset;
    logic [SLOT_W-1:0] tx_len;
  } grant_entry_s;

  typedef struct packed {
    logic valid;
    sid_class_e cls;
    logic usable;
    logic prio_ok;
    logic [NIB_W-1:0] spacing;
  } grant_decision_s;
endpackage
`default_nettype wire

//--- src/slot_spacing_check.sv
// start-spacing and size check for size-limited multicast intervals
`default_nettype none
module slot_spacing_check #(
  parameter int SLOT_W = grant_id_pkg::SLOT_W
) (
  // interval limit
  input wire logic [grant_id_pkg::NIB_W-1:0] spacing,
  // planned burst
  input wire logic [SLOT_W-1:0] tx_offset,
  input wire logic [SLOT_W-1:0] tx_len,
  // verdict
  output logic fits
);
  logic [SLOT_W-1:0] n_wide;
  logic [SLOT_W-1:0] rem;

  always_comb begin
    n_wide = SLOT_W'(spacing);
    rem = (spacing == '0) ? '1 : SLOT_W'(tx_offset % n_wide);
    // offset counts from the interval's first mini-slot, so slot zero is a legal start for any nonzero spacing
    fits = (spacing != '0) && (rem == '0) && (tx_len != '0) && (tx_len <= n_wide);
  end
endmodule
`default_nettype wire

//--- src/mac_dest_filter.sv
// destination address classification for the modem mac sublayer
`default_nettype none
module mac_dest_filter (
  // destination as received, first octet in bits 47:40
  input wire logic [47:0] dest_addr,
  // classification
  output logic all_modem,
  output logic reserved,
  output logic group
);
  always_comb begin
    // octets keep wire order and each octet's lsb went first, so bit 40 is the group bit
    group = dest_addr[grant_id_pkg::MAC_GROUP_BIT];
    all_modem = (dest_addr == grant_id_pkg::MAC_ALL_MODEM);
    reserved = (dest_addr[47:grant_id_pkg::MAC_RSVD_HI_LSB] == grant_id_pkg::MAC_RSVD_HI)
      && (dest_addr[grant_id_pkg::MAC_RSVD_HI_LSB-1:0] >= grant_id_pkg::MAC_RSVD_LO_MIN);
  end
endmodule
`default_nettype wire

//--- src/grant_id_decoder.sv
// well-known identifier decoder, destination filter and carrier watchdog of the cable modem
`default_nettype none
module grant_id_decoder #(
  parameter int NUM_OWN_IDS = 4,
  parameter int TX_LIMIT_CYCLES = grant_id_pkg::TX_LIMIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // grant entry from the map parser
  input wire grant_id_pkg::grant_entry_s grant_entry,
  // modem context
  input wire logic unicast_assigned,
  input wire logic [grant_id_pkg::SID_W-1:0] own_ids [NUM_OWN_IDS],
  input wire logic [NUM_OWN_IDS-1:0] own_id_valid,
  input wire logic want_request,
  input wire logic [grant_id_pkg::PRIO_W-1:0] flow_priority,
  // received frame destination
  input wire logic dest_valid,
  input wire logic [47:0] dest_addr,
  // transport packet header
  input wire logic pid_valid,
  input wire logic [grant_id_pkg::PID_W-1:0] pid,
  // transmitter carrier state
  input wire logic carrier_on,
  input wire logic rf_cutoff_clear,
  // grant decision
  output grant_id_pkg::grant_decision_s decision,
  output logic [grant_id_pkg::SID_W-1:0] tx_service_flow_id,
  // frame verdicts
  output logic frame_accept,
  output logic frame_no_forward,
  output logic data_packet,
  // watchdog
  output logic rf_cutoff
);
  localparam int CNT_W = $clog2(TX_LIMIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(TX_LIMIT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    grant_id_pkg::grant_decision_s dec;
    logic [grant_id_pkg::SID_W-1:0] tx_sid;
    logic accept;
    logic no_forward;
    logic data_pkt;
    logic [CNT_W-1:0] on_cnt;
    logic cutoff;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [NUM_OWN_IDS-1:0] own_match;
  logic own_hit;
  logic mcast_fits;
  logic dest_all_modem;
  logic dest_reserved;
  logic dest_group;
  logic [grant_id_pkg::NIB_W-1:0] sid_digit;

  function automatic logic is_mcast_sid(input logic [grant_id_pkg::SID_W-1:0] service_flow_id);
    logic [grant_id_pkg::NIB_W-1:0] n;
    n = service_flow_id[grant_id_pkg::NIB_W-1:0];
    is_mcast_sid = (service_flow_id[grant_id_pkg::SID_W-1:grant_id_pkg::MCAST_HI_LSB] == grant_id_pkg::SID_MCAST_HI)
      && (n >= grant_id_pkg::MCAST_N_MIN) && (n <= grant_id_pkg::MCAST_N_MAX);
  endfunction

  function automatic logic is_prio_sid(input logic [grant_id_pkg::SID_W-1:0] service_flow_id);
    is_prio_sid = (service_flow_id[grant_id_pkg::SID_W-1:grant_id_pkg::PRIO_HI_LSB] == grant_id_pkg::SID_PRIO_HI);
  endfunction

  assign sid_digit = grant_entry.service_flow_id[grant_id_pkg::NIB_W-1:0];

  // one comparator per identifier the head end handed to this modem
  generate
    for (genvar i = 0; i < NUM_OWN_IDS; i++) begin : g_own
      assign own_match[i] = unicast_assigned && own_id_valid[i] && (own_ids[i] == grant_entry.service_flow_id);
    end
  endgenerate
  assign own_hit = |own_match;

  slot_spacing_check #(
    .SLOT_W(grant_id_pkg::SLOT_W)
  ) u_spacing (
    .spacing(sid_digit),
    .tx_offset(grant_entry.tx_offset),
    .tx_len(grant_entry.tx_len),
    .fits(mcast_fits)
  );

  mac_dest_filter u_dest (
    .dest_addr(dest_addr),
    .all_modem(dest_all_modem),
    .reserved(dest_reserved),
    .group(dest_group)
  );

  always_comb begin
    state_next = state_reg;

    // grant entry decode
    state_next.dec.valid = grant_entry.valid;
    state_next.dec.cls = grant_id_pkg::CLS_NONE;
    state_next.dec.usable = 1'b0;
    state_next.dec.prio_ok = 1'b0;
    state_next.dec.spacing = '0;
    if (grant_entry.valid) begin
      if (own_hit) begin
        state_next.dec.cls = grant_id_pkg::CLS_UNICAST;
        state_next.dec.usable = 1'b1;
      end else if (grant_entry.service_flow_id == grant_id_pkg::SID_NO_MODEM) begin
        state_next.dec.cls = grant_id_pkg::CLS_NO_MODEM;
        state_next.dec.usable = 1'b0;
      end else if (grant_entry.service_flow_id == grant_id_pkg::SID_ALL_MODEM) begin
        state_next.dec.cls = grant_id_pkg::CLS_ALL_MODEM;
        state_next.dec.usable = 1'b1;
      end else if (is_mcast_sid(grant_entry.service_flow_id)) begin
        state_next.dec.cls = grant_id_pkg::CLS_MULTICAST;
        state_next.dec.spacing = sid_digit;
        state_next.dec.usable = (grant_entry.interval_usage_code == grant_id_pkg::IUC_REQ_DATA) && mcast_fits;
      end else if (is_prio_sid(grant_entry.service_flow_id)) begin
        state_next.dec.cls = grant_id_pkg::CLS_PRIORITY;
        state_next.dec.prio_ok = grant_entry.service_flow_id[flow_priority];
        state_next.dec.usable = (grant_entry.interval_usage_code == grant_id_pkg::IUC_REQUEST)
          && grant_entry.service_flow_id[flow_priority] && want_request;
      end else begin
        // someone else's unicast identifier
        state_next.dec.cls = grant_id_pkg::CLS_OTHER;
        state_next.dec.usable = 1'b0;
      end
      // no grant is used while the transmitter is cut off
      if (state_reg.cutoff) begin
        state_next.dec.usable = 1'b0;
      end
    end

    if (unicast_assigned && own_id_valid[0]) begin
      state_next.tx_sid = own_ids[0];
    end else begin
      state_next.tx_sid = grant_id_pkg::SID_INIT_RANGING;
    end

    // received frame verdicts, held until the next destination arrives
    if (dest_valid) begin
      state_next.accept = dest_all_modem;
      state_next.no_forward = dest_reserved && dest_group;
    end

    if (pid_valid) begin
      state_next.data_pkt = (pid == grant_id_pkg::PID_DATA);
    end else begin
      state_next.data_pkt = 1'b0;
    end

    if (!carrier_on) begin
      state_next.on_cnt = '0;
    end else if (state_reg.on_cnt != CNT_LIMIT) begin
      state_next.on_cnt = state_reg.on_cnt + CNT_ONE;
    end
    // a new trip in the same cycle as a clear keeps the cutoff set
    if (carrier_on && (state_reg.on_cnt == CNT_LIMIT)) begin
      state_next.cutoff = 1'b1;
    end else if (rf_cutoff_clear) begin
      state_next.cutoff = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign decision = state_reg.dec;
  assign tx_service_flow_id = state_reg.tx_sid;
  assign frame_accept = state_reg.accept;
  assign frame_no_forward = state_reg.no_forward;
  assign data_packet = state_reg.data_pkt;
  // cutoff gates the rf enable outside this block
  assign rf_cutoff = state_reg.cutoff;
endmodule
`default_nettype wire

//--- verification/grant_id_decoder_chk.sv
// assertion checker bound to the grant identifier decoder
`default_nettype none
module grant_id_decoder_chk #(
  parameter int TX_LIMIT_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched inputs
  input wire grant_id_pkg::grant_entry_s grant_entry,
  input wire logic want_request,
  input wire logic [grant_id_pkg::PRIO_W-1:0] flow_priority,
  input wire logic dest_valid,
  input wire logic [47:0] dest_addr,
  input wire logic pid_valid,
  input wire logic [grant_id_pkg::PID_W-1:0] pid,
  input wire logic carrier_on,
  // watched outputs
  input wire grant_id_pkg::grant_decision_s decision,
  input wire logic frame_no_forward,
  input wire logic data_packet,
  input wire logic rf_cutoff
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // saturates one past the limit so the count stays small
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      run <= 0;
    else
      run <= !carrier_on ? 0 : (run > TX_LIMIT_CYCLES ? run : run + 1);
  end
  property p_entry_lat; grant_entry.valid |=> decision.valid; endproperty
  a_entry_lat: assert property (p_entry_lat) else $error("no decision after entry");
  // a no-modem entry must come out valid, classed no-modem and unusable unless it matched one of our own identifiers
  property p_no_modem;
    grant_entry.valid && grant_entry.service_flow_id == grant_id_pkg::SID_NO_MODEM |=> decision.valid
      && (decision.cls == grant_id_pkg::CLS_UNICAST || decision.cls == grant_id_pkg::CLS_NO_MODEM && !decision.usable);
  endproperty
  a_no_modem: assert property (p_no_modem) else $error("no-modem entry usable");
  property p_mcast;
    decision.usable && decision.cls == grant_id_pkg::CLS_MULTICAST |-> decision.spacing == $past(grant_entry.service_flow_id[3:0])
      && $past(grant_entry.interval_usage_code) == grant_id_pkg::IUC_REQ_DATA && $past(grant_entry.tx_len) <= decision.spacing
      && $past(grant_entry.tx_len) != 0 && $past(grant_entry.tx_offset) % decision.spacing == 0;
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast slot rule broken");
  property p_prio;
    decision.valid && decision.cls == grant_id_pkg::CLS_PRIORITY |-> decision.prio_ok == $past(grant_entry.service_flow_id[flow_priority])
      && (!decision.usable || decision.prio_ok && $past(want_request) && $past(grant_entry.interval_usage_code) == grant_id_pkg::IUC_REQUEST);
  endproperty
  a_prio: assert property (p_prio) else $error("priority mask misused");
  property p_trip; run > TX_LIMIT_CYCLES |-> rf_cutoff; endproperty
  a_trip: assert property (p_trip) else $error("carrier not cut off");
  property p_cut_block; rf_cutoff && grant_entry.valid |=> !decision.usable; endproperty
  a_cut_block: assert property (p_cut_block) else $error("usable while cut off");
  property p_pid; pid_valid && pid == grant_id_pkg::PID_DATA |=> data_packet; endproperty
  a_pid: assert property (p_pid) else $error("data packet missed");
  property p_rsvd;
    dest_valid && dest_addr[47:4] == grant_id_pkg::MAC_RSVD_HI && dest_addr[3:0] >= 4'h2 |=> frame_no_forward;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved address forwarded");
  cover property (decision.usable && decision.cls == grant_id_pkg::CLS_MULTICAST);
  cover property (decision.usable && decision.cls == grant_id_pkg::CLS_PRIORITY);
  cover property ($rose(rf_cutoff));
endmodule
bind grant_id_decoder grant_id_decoder_chk #(.TX_LIMIT_CYCLES(TX_LIMIT_CYCLES)) chk (.clk(clk), .rst(rst),
  .grant_entry(grant_entry), .want_request(want_request), .flow_priority(flow_priority), .dest_valid(dest_valid),
  .dest_addr(dest_addr), .pid_valid(pid_valid), .pid(pid), .carrier_on(carrier_on), .decision(decision),
  .frame_no_forward(frame_no_forward), .data_packet(data_packet), .rf_cutoff(rf_cutoff));
`default_nettype wire

//--- verification/grant_sched_model.sv
// head-end scheduler model issuing grant entries
`default_nettype none
module grant_sched_model (
  // clock and pacing
  input wire logic clk,
  input wire logic slow,
  // identifier assigned to the modem
  input wire logic [grant_id_pkg::SID_W-1:0] own_id,
  // entry to the modem
  output grant_id_pkg::grant_entry_s grant_entry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] service_flow_id;
  grant_id_pkg::grant_entry_s g;
  initial grant_entry = '0;
  always @(posedge clk) begin
    case ($urandom % 6)
      0: service_flow_id = 14'h0000;
      1: service_flow_id = 14'h3fff;
      2: service_flow_id = {10'h3ff, 4'($urandom)};
      3: service_flow_id = {6'h3e, 8'($urandom)};
      4: service_flow_id = own_id;
      default: service_flow_id = 14'($urandom);
    endcase
    g = '{1'b1, service_flow_id, 4'(1 + $urandom % 3), 10'($urandom % 32), 10'($urandom % 16)};
    // idle cycles invert the previous fields, so stale values come back on every second idle cycle in a row
    if (slow && $urandom % 2) begin
      g = ~grant_entry;
      g.valid = 1'b0;
    end
    grant_entry <= g;
  end
endmodule
`default_nettype wire

//--- verification/upstream_grant_id_decoder_tb.sv
// self-checking bench for the grant identifier decoder
`default_nettype none
module upstream_grant_id_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 8;
  logic clk = 0, rst = 1, slow = 0, ua = 0, wr = 0, dv = 0, pv = 0, co = 0, clr = 0;
  logic [2:0] fp = '0;
  logic [3:0] ov = '0;
  logic [12:0] pid = '0;
  logic [47:0] da = '0;
  logic [13:0] own [4];
  logic [13:0] txid;
  logic acc, nofw, dpk, cut;
  grant_id_pkg::grant_entry_s ge;
  grant_id_pkg::grant_decision_s dec, e_dec;
  logic e_acc, e_nofw, e_dpk, e_cut;
  logic [13:0] e_tx;
  int bad_count = 0, n_checks = 0, cyc = 0, run = 0;
  grant_sched_model partner (.clk(clk), .slow(slow), .own_id(own[1]), .grant_entry(ge));
  grant_id_decoder #(.NUM_OWN_IDS(4), .TX_LIMIT_CYCLES(LIM)) dut (.clk(clk), .rst(rst), .grant_entry(ge),
    .unicast_assigned(ua), .own_ids(own), .own_id_valid(ov), .want_request(wr), .flow_priority(fp),
    .dest_valid(dv), .dest_addr(da), .pid_valid(pv), .pid(pid), .carrier_on(co), .rf_cutoff_clear(clr),
    .decision(dec), .tx_service_flow_id(txid), .frame_accept(acc), .frame_no_forward(nofw),
    .data_packet(dpk), .rf_cutoff(cut));
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic grant_id_pkg::grant_decision_s model(grant_id_pkg::grant_entry_s g, logic blocked);
    grant_id_pkg::grant_decision_s d;
    logic hit;
    int n;
    d = '0;
    hit = 0;
    n = g.service_flow_id % 16;
    foreach (own[i]) hit |= ua && ov[i] && own[i] == g.service_flow_id;
    d.valid = g.valid;
    d.cls = hit ? grant_id_pkg::CLS_UNICAST : g.service_flow_id == 0 ? grant_id_pkg::CLS_NO_MODEM :
      g.service_flow_id == 14'h3fff ? grant_id_pkg::CLS_ALL_MODEM : g.service_flow_id[13:4] == 10'h3ff && n > 0 ? grant_id_pkg::CLS_MULTICAST :
      g.service_flow_id[13:8] == 6'h3e ? grant_id_pkg::CLS_PRIORITY : grant_id_pkg::CLS_OTHER;
    case (d.cls)
      grant_id_pkg::CLS_UNICAST, grant_id_pkg::CLS_ALL_MODEM: d.usable = 1;
      grant_id_pkg::CLS_MULTICAST: d.usable = g.interval_usage_code == 2 && g.tx_len >= 1 && g.tx_len <= n && g.tx_offset % n == 0;
      grant_id_pkg::CLS_PRIORITY: d.usable = g.interval_usage_code == 1 && wr && g.service_flow_id[fp];
      default: d.usable = 0;
    endcase
    d.usable &= !blocked;
    d.prio_ok = g.service_flow_id[fp];
    d.spacing = 4'(n);
    return d;
  endfunction
  always @(posedge clk) begin
    if (rst) begin
      {e_dec, e_acc, e_nofw, e_dpk, e_cut, e_tx} = '0;
      run = 0;
    end else begin
      check("valid", dec.valid, e_dec.valid);
      if (e_dec.valid) begin
        check("cls", dec.cls, e_dec.cls);
        check("usable", dec.usable, e_dec.usable);
        if (e_dec.cls == grant_id_pkg::CLS_PRIORITY) check("prio_ok", dec.prio_ok, e_dec.prio_ok);
        if (e_dec.cls == grant_id_pkg::CLS_MULTICAST) check("spacing", dec.spacing, e_dec.spacing);
      end
      check("tx id", txid, e_tx);
      check("accept", acc, e_acc);
      check("no_forward", nofw, e_nofw);
      check("data_packet", dpk, e_dpk);
      check("rf_cutoff", cut, e_cut);
      e_dec = model(ge, e_cut);
      e_tx = ua && ov[0] ? own[0] : 14'h0;
      if (dv) begin
        e_acc = da == 48'h01e02f000001;
        e_nofw = da[47:4] == 44'h01e02f00000 && da[3:0] >= 2;
      end
      e_dpk = pv && pid == 13'h1ffe;
      run = co ? run + 1 : 0;
      e_cut = run > LIM ? 1'b1 : clr ? 1'b0 : e_cut;
    end
  end
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hda5c58f9));
    foreach (own[i]) own[i] = 14'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4000; k++) begin
      @(posedge clk);
      slow <= k > 2000;
      if (k % 500 == 499) ua <= 1'($urandom);
      ov <= 4'($urandom);
      wr <= 1'($urandom);
      fp <= 3'($urandom);
      dv <= 1'($urandom);
      da <= $urandom % 4 ? {40'h01e02f0000, 8'($urandom % 32)} : {16'($urandom), 32'($urandom)};
      pv <= 1'($urandom);
      pid <= $urandom % 2 ? 13'h1ffe : 13'($urandom);
      // long carrier runs in one half trip the cutoff, the other half lets it clear
      co <= k % 1000 < 500 ? $urandom % 16 != 0 : $urandom % 4 == 0;
      clr <= $urandom % 8 == 0;
    end
    end_of_test();
  end
endmodule
`default_nettype wire
